// *** hdl/conv_map.vh ***
`ifndef CONV_MAP_VH
`define CONV_MAP_VH

// register byte addresses
`define OFS_RESULT_LO   8'h00
`define OFS_RESULT_HI   8'h04
`define OFS_CONTROL_B   8'h08
`define OFS_BUF_DIS_0   8'h0c
`define OFS_CONTROL_A   8'h10
`define OFS_ALIGN       8'h14

// control register a fields
`define CA_ENABLE       7
`define CA_START        6
`define CA_AUTO_TRIG    5
`define CA_DONE         4
`define CA_DIV_HI       2
`define CA_DIV_LO       0

// control register b fields
`define CB_BIPOLAR      7
`define CB_CMP_HI       6
`define CB_CMP_LO       4
`define CB_RESERVED     3
`define CB_TRIG_HI      2
`define CB_TRIG_LO      0

// alignment register field
`define AL_LEFT         5

// reset values
`define RST_BYTE        8'h00
`define RST_RESULT      10'h000
`define RST_TRIG_SEL    3'h0

// codes and counts
`define TRIG_FREE_RUN   3'h0
`define CONV_TICKS      5'h0d
`define FIRST_TICKS     5'h19
`define DIV_MIN         8'h02
`define UNI_FULL        10'h3ff
`define BIP_MAX         11'sh1ff
`define BIP_MIN         -11'sh200

`endif

// *** hdl/conv_clk_prescaler.v ***
`timescale 1ns/100ps
`include "conv_map.vh"

module conv_clk_prescaler (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       run,
  input  wire [2:0] div_sel,
  output wire       tick
);

  reg  [7:0] cnt_q;
  reg  [7:0] cnt_d;
  wire [7:0] limit;

  // codes 0 and 1 both divide by two
  function [7:0] divisor;
    input [2:0] sel;
    begin
      if (sel <= 3'h1) begin
        divisor = `DIV_MIN;
      end else begin
        divisor = 8'h01 << sel;
      end
    end
  endfunction

  assign limit = divisor(div_sel) - 8'h01;
  assign tick  = run && (cnt_q >= limit);

  always @* begin
    if (!run || tick) begin
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // conv_clk_prescaler

// *** hdl/trigger_edge_detect.v ***
`timescale 1ns/100ps
`include "conv_map.vh"

module trigger_edge_detect (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       enable,
  input  wire [2:0] sel,
  input  wire [7:0] flags,
  output wire       trig
);

  reg  [2:0] sel_prev_q;
  reg        lvl_prev_q;
  wire       level;
  wire       to_free;

  // index 0 is the conversion-done flag itself
  assign level   = flags[sel];
  // entering free running never fires, even with done set
  assign to_free = (sel == `TRIG_FREE_RUN) && (sel_prev_q != `TRIG_FREE_RUN);
  // a switch to a source other than free running that raises the level counts as an edge
  assign trig    = enable && level && !lvl_prev_q && !to_free;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_prev_q <= `RST_TRIG_SEL;
      lvl_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel;
      lvl_prev_q <= level;
    end
  end

endmodule // trigger_edge_detect

// *** hdl/converter_result_and_trigger_ctrl.v ***
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "conv_map.vh"
// Summary of operation
// - a finished conversion loads the read-only result unless locked or a result read or write is in flight
// - low byte read locks result until high read
// - right aligned: low 7:0, high 1:0
// - left aligned: high 9:2, low 7:6
// - unipolar result saturates to full scale
// - bipolar select gives two's complement result
// - control b bit 3 reads zero
// - trigger source ignored unless auto-trigger on
// - auto trigger starts on selected flag rise
// - switching from a clear to a set source other than free running is an edge
// - switching to free running never triggers
// - trigger codes map eight sources in order
// - input-disable bit forces pin read zero
// - done flag sets when result is updated
// - alignment change shows in view at once
// - converter clock divided by prescaler table
// - auto trigger on positive trigger edge

module converter_result_and_trigger_ctrl #(
  parameter PIN_N = 8
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire [7:1]       trig_src_flags,
  input  wire [10:0]      diff_code,
  output reg              sample_start,
  output wire             conv_clk_tick,
  output wire             conv_busy,
  input  wire [PIN_N-1:0] pin_in,
  output reg  [PIN_N-1:0] pin_read,
  output wire [PIN_N-1:0] buffer_off,
  output wire [2:0]       comparator_ctrl
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  // clamp limits kept at full width so the signed compare sees the sign
  localparam signed [10:0] BIP_HI = `BIP_MAX;
  localparam signed [10:0] BIP_LO = `BIP_MIN;

  // control register a
  reg             enable_q;
  reg             auto_trig_q;
  reg             done_q;
  reg  [2:0]      div_q;
  // control register b
  reg             bipolar_q;
  reg  [2:0]      cmp_q;
  reg  [2:0]      trig_sel_q;
  // other storage
  reg             align_q;
  reg  [PIN_N-1:0] buf_dis_q;
  reg  [9:0]      result_q;
  reg             lock_q;
  reg             first_q;
  reg             state_q;
  reg             state_d;
  reg  [4:0]      tick_cnt_q;
  reg  [4:0]      tick_cnt_d;
  reg  [7:0]      rd_byte;

  wire            setup_ph;
  wire            acc_wr;
  wire            acc_rd;
  wire            wr_ctl_a;
  wire            wr_ctl_b;
  wire            wr_align;
  wire            wr_buf;
  wire            rd_lo;
  wire            rd_hi;
  wire            manual_start;
  wire            trig;
  wire            start_conv;
  wire            tick;
  wire [4:0]      tick_limit;
  wire            conv_end;
  wire            res_access;
  wire            res_load;
  wire            done_clr;
  wire [7:0]      lo_view;
  wire [7:0]      hi_view;
  reg  [7:0]      ctl_a_view;
  reg  [7:0]      ctl_b_view;

  function mapped;
    input [7:0] a;
    begin
      case (a)
        `OFS_RESULT_LO,
        `OFS_RESULT_HI,
        `OFS_CONTROL_B,
        `OFS_BUF_DIS_0,
        `OFS_CONTROL_A,
        `OFS_ALIGN: mapped = 1'b1;
        default:    mapped = 1'b0;
      endcase
    end
  endfunction

  // diff_code is positive input minus negative input, signed
  function [9:0] code_convert;
    input        bip;
    input [10:0] d;
    begin
      if (bip) begin
        if ($signed(d) > BIP_HI) begin
          code_convert = BIP_HI[9:0];
        end else if ($signed(d) < BIP_LO) begin
          code_convert = BIP_LO[9:0];
        end else begin
          code_convert = d[9:0];
        end
      end else begin
        // negative difference pins at full scale, not zero
        if (d[10] || d[9:0] > `UNI_FULL) begin
          code_convert = `UNI_FULL;
        end else begin
          code_convert = d[9:0];
        end
      end
    end
  endfunction

  // apb decode
  assign setup_ph = psel && !penable;
  assign acc_wr   = psel && penable && pwrite;
  assign acc_rd   = psel && penable && !pwrite;
  assign wr_ctl_a = acc_wr && (paddr == `OFS_CONTROL_A);
  assign wr_ctl_b = acc_wr && (paddr == `OFS_CONTROL_B);
  assign wr_align = acc_wr && (paddr == `OFS_ALIGN);
  assign wr_buf   = acc_wr && (paddr == `OFS_BUF_DIS_0);
  assign rd_lo    = acc_rd && (paddr == `OFS_RESULT_LO);
  assign rd_hi    = acc_rd && (paddr == `OFS_RESULT_HI);

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // result views follow the alignment bit combinationally
  assign lo_view = align_q ? {result_q[1:0], 6'h00}
                           : result_q[7:0];
  assign hi_view = align_q ? result_q[9:2]
                           : {6'h00, result_q[9:8]};

  // fields placed one by one; unused bits keep the reset byte's zero
  always @* begin
    ctl_a_view                          = `RST_BYTE;
    ctl_a_view[`CA_ENABLE]              = enable_q;
    ctl_a_view[`CA_START]               = conv_busy;
    ctl_a_view[`CA_AUTO_TRIG]           = auto_trig_q;
    ctl_a_view[`CA_DONE]                = done_q;
    ctl_a_view[`CA_DIV_HI:`CA_DIV_LO]   = div_q;
    ctl_b_view                          = `RST_BYTE;
    ctl_b_view[`CB_BIPOLAR]             = bipolar_q;
    ctl_b_view[`CB_CMP_HI:`CB_CMP_LO]   = cmp_q;
    ctl_b_view[`CB_TRIG_HI:`CB_TRIG_LO] = trig_sel_q;
  end

  always @* begin
    case (paddr)
      `OFS_RESULT_LO: rd_byte = lo_view;
      `OFS_RESULT_HI: rd_byte = hi_view;
      `OFS_CONTROL_B: rd_byte = ctl_b_view;
      `OFS_BUF_DIS_0: rd_byte = buf_dis_q;
      `OFS_CONTROL_A: rd_byte = ctl_a_view;
      `OFS_ALIGN: begin
        rd_byte           = `RST_BYTE;
        rd_byte[`AL_LEFT] = align_q;
      end
      default:        rd_byte = `RST_BYTE;
    endcase
  end

  // read data latched in the setup cycle, valid through the access
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // configuration storage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q    <= 1'b0;
      auto_trig_q <= 1'b0;
      div_q       <= 3'h0;
      bipolar_q   <= 1'b0;
      cmp_q       <= 3'h0;
      trig_sel_q  <= `RST_TRIG_SEL;
      align_q     <= 1'b0;
      buf_dis_q   <= {PIN_N{1'b0}};
    end else begin
      if (wr_ctl_a) begin
        enable_q    <= pwdata[`CA_ENABLE];
        auto_trig_q <= pwdata[`CA_AUTO_TRIG];
        div_q       <= pwdata[`CA_DIV_HI:`CA_DIV_LO];
      end
      if (wr_ctl_b) begin
        bipolar_q  <= pwdata[`CB_BIPOLAR];
        cmp_q      <= pwdata[`CB_CMP_HI:`CB_CMP_LO];
        trig_sel_q <= pwdata[`CB_TRIG_HI:`CB_TRIG_LO];
      end
      if (wr_align) begin
        align_q <= pwdata[`AL_LEFT];
      end
      if (wr_buf) begin
        buf_dis_q <= pwdata[PIN_N-1:0];
      end
    end
  end

  assign comparator_ctrl = cmp_q;
  assign buffer_off      = buf_dis_q;

  // port read path: a disabled buffer reads as zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_read <= {PIN_N{1'b0}};
    end else begin
      pin_read <= pin_in & ~buf_dis_q;
    end
  end

  conv_clk_prescaler u_prescaler (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (enable_q),
    .div_sel (div_q),
    .tick    (tick)
  );

  trigger_edge_detect u_trigger (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (auto_trig_q),
    .sel     (trig_sel_q),
    .flags   ({trig_src_flags, done_q}),
    .trig    (trig)
  );

  assign conv_clk_tick = tick;
  assign conv_busy     = (state_q == ST_CONV);

  // start is honoured only when the same write also sets the enable bit
  assign manual_start = wr_ctl_a && pwdata[`CA_START] && pwdata[`CA_ENABLE];
  // starts during a conversion are dropped, not queued
  assign start_conv   = !conv_busy && (manual_start || (enable_q && trig));
  assign tick_limit   = first_q ? `FIRST_TICKS : `CONV_TICKS;
  assign conv_end     = conv_busy && enable_q && tick && (tick_cnt_q == tick_limit - 5'h01);

  always @* begin
    state_d    = state_q;
    tick_cnt_d = tick_cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (start_conv) begin
          state_d    = ST_CONV;
          tick_cnt_d = 5'h00;
        end
      end
      ST_CONV: begin
        if (!enable_q || conv_end) begin
          state_d = ST_IDLE;
        end else if (tick) begin
          tick_cnt_d = tick_cnt_q + 5'h01;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= ST_IDLE;
      tick_cnt_q   <= 5'h00;
      first_q      <= 1'b1;
      sample_start <= 1'b0;
    end else begin
      state_q      <= state_d;
      tick_cnt_q   <= tick_cnt_d;
      sample_start <= (state_q == ST_IDLE) && start_conv;
      // turning the converter off makes the next conversion a long one
      if (!enable_q) begin
        first_q <= 1'b1;
      end else if (conv_end) begin
        first_q <= 1'b0;
      end
    end
  end

  // a result read in flight also holds off the update, so the
  // byte latched in setup and the lock always refer to one value
  assign res_access = psel && ((paddr == `OFS_RESULT_LO) || (paddr == `OFS_RESULT_HI));
  assign res_load   = conv_end && !lock_q && !res_access;
  assign done_clr   = wr_ctl_a && pwdata[`CA_DONE];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= `RST_RESULT;
      lock_q   <= 1'b0;
    end else begin
      if (res_load) begin
        result_q <= code_convert(bipolar_q, diff_code);
      end
      if (rd_hi) begin
        lock_q <= 1'b0;
      end else if (rd_lo) begin
        lock_q <= 1'b1;
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else if (res_load) begin
      done_q <= 1'b1;
    end else if (done_clr) begin
      done_q <= 1'b0;
    end
  end

endmodule // converter_result_and_trigger_ctrl

// *** dv/converter_result_and_trigger_ctrl_checker.sv ***
`timescale 1ns/100ps
`include "conv_map.vh"
module converter_result_and_trigger_ctrl_checker #(
  parameter PIN_N = 8
) (
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             sample_start,
  input wire logic             conv_clk_tick,
  input wire logic             conv_busy,
  input wire logic [PIN_N-1:0] pin_in,
  input wire logic [PIN_N-1:0] pin_read,
  input wire logic [PIN_N-1:0] buffer_off,
  input wire logic [2:0]       comparator_ctrl
);
  logic [4:0] tk_q;
  wire        acc = psel && penable;
  wire        wr_b = acc && pwrite && paddr == `OFS_CONTROL_B;
  wire        map = paddr[1:0] == 2'h0 && paddr <= `OFS_ALIGN;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ticks seen while busy; aborts are not exercised, so no escape for them
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) tk_q <= 5'h00;
    else tk_q <= conv_busy ? tk_q + {4'h0, conv_clk_tick} : 5'h00;
  end
  ready_always_a: assert property (pready) else $error("pready low");
  map_err_a: assert property (acc && !map |-> pslverr) else $error("no error on unmapped");
  err_scope_a: assert property (pslverr |-> acc) else $error("error outside access");
  res_zero_a: assert property (acc && !pwrite && paddr == `OFS_CONTROL_B |-> !prdata[3])
    else $error("reserved bit set");
  pin_mask_a: assert property ($past(reset_n) |-> pin_read == ($past(pin_in) & ~$past(buffer_off)))
    else $error("pin read not masked");
  start_pulse_a: assert property (sample_start |-> $rose(conv_busy) ##1 !sample_start)
    else $error("bad start pulse");
  busy_start_a: assert property ($rose(conv_busy) |-> sample_start) else $error("busy without start");
  conv_len_a: assert property ($fell(conv_busy) |-> tk_q == `CONV_TICKS || tk_q == `FIRST_TICKS)
    else $error("wrong conversion length");
  cmp_hold_a: assert property ($changed(comparator_ctrl) |-> $past(wr_b))
    else $error("comparator bits moved");
  cover property ($fell(conv_busy));
  cover property (pslverr);
  cover property (|(pin_in & buffer_off));
  cover property (sample_start);
endmodule // converter_result_and_trigger_ctrl_checker

bind converter_result_and_trigger_ctrl converter_result_and_trigger_ctrl_checker #(.PIN_N(PIN_N)) chk_inst (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_start(sample_start),
  .conv_clk_tick(conv_clk_tick), .conv_busy(conv_busy), .pin_in(pin_in), .pin_read(pin_read),
  .buffer_off(buffer_off), .comparator_ctrl(comparator_ctrl));

// *** dv/converter_result_and_trigger_ctrl_tb_top.sv ***
`timescale 1ns/100ps
`include "conv_map.vh"
module converter_result_and_trigger_ctrl_tb_top;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic        sample_start, conv_clk_tick, conv_busy;
  logic [7:0]  paddr, pin_in, pin_read, buffer_off, rd;
  logic [31:0] pwdata, prdata;
  logic [10:0] diff_code;
  logic [7:1]  trig_src_flags;
  logic [2:0]  comparator_ctrl;
  int          err_count, comparisons, cyc;

  converter_result_and_trigger_ctrl converter_result_and_trigger_ctrl_inst (.clk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trig_src_flags, .diff_code, .sample_start,
    .conv_clk_tick, .conv_busy, .pin_in, .pin_read, .buffer_off, .comparator_ctrl);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task tally_and_finish;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish;
    end
  end

  task chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  // waits for pready as long as it takes; only the bench timeout ends a hang
  task apb(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rdc(input logic [7:0] a, e, input string s);
    apb(0, a, 8'h00);
    chk(s, e, rd);
  endtask

  task wait_idle;
    @(posedge clk);
    while (conv_busy !== 1'b0) begin
      @(posedge clk);
    end
  endtask

  task conv(input logic [10:0] d);
    diff_code <= d;
    apb(1, `OFS_CONTROL_A, 8'hc0);
    wait_idle;
  endtask

  // a start may lag the flag by a few cycles; six covers the edge detector
  task strt(input logic e, input string s);
    logic v;
    v = 0;
    repeat (6) begin
      @(posedge clk);
      v = v | sample_start;
    end
    chk(s, e, v);
    wait_idle;
  endtask

  task gap(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (conv_clk_tick !== 1'b1 && n < 300);
  endtask

  task regs_tc;
    rdc(`OFS_CONTROL_B, 8'h00, "ctl_b");
    rdc(`OFS_BUF_DIS_0, 8'h00, "buf_dis");
    rdc(`OFS_RESULT_LO, 8'h00, "res_lo");
    rdc(`OFS_RESULT_HI, 8'h00, "res_hi");
    apb(0, 8'h18, 8'h00);
    chk("slverr", 1, er);
    apb(1, `OFS_CONTROL_B, 8'hf7);
    rdc(`OFS_CONTROL_B, 8'hf7, "ctl_b");
    chk("cmp_ctrl", 3'h7, comparator_ctrl);
    apb(1, `OFS_CONTROL_B, 8'h00);
  endtask

  task pins_tc;
    pin_in <= 8'hff;
    apb(1, `OFS_BUF_DIS_0, 8'ha5);
    pin_in <= 8'h3c;
    repeat (2) @(posedge clk);
    chk("pin_read", 8'h18, pin_read);
    chk("buf_off", 8'ha5, buffer_off);
    rdc(`OFS_BUF_DIS_0, 8'ha5, "buf_dis");
  endtask

  task div_tc;
    int dv[8] = '{2, 2, 4, 8, 16, 32, 64, 128};
    int n;
    for (int c = 0; c < 8; c++) begin
      apb(1, `OFS_CONTROL_A, 8'h80 | c[7:0]);
      gap(n);
      gap(n);
      gap(n);
      chk("tick_gap", dv[c], n);
    end
  endtask

  task conv_tc;
    logic [10:0] cd[6] = '{11'h155, 11'h7fb, 11'h500, 11'h7fd, 11'h300, 11'h400};
    logic [9:0]  ex[6] = '{10'h155, 10'h3ff, 10'h3ff, 10'h3fd, 10'h1ff, 10'h200};
    for (int i = 0; i < 6; i++) begin
      apb(1, `OFS_CONTROL_B, i > 2 ? 8'h80 : 8'h00);
      conv(cd[i]);
      rdc(`OFS_CONTROL_A, 8'h90, "done");
      apb(1, `OFS_CONTROL_A, 8'h90);
      rdc(`OFS_RESULT_LO, ex[i][7:0], "lo_right");
      rdc(`OFS_RESULT_HI, {6'h0, ex[i][9:8]}, "hi_right");
      apb(1, `OFS_ALIGN, 8'h20);
      rdc(`OFS_RESULT_LO, {ex[i][1:0], 6'h0}, "lo_left");
      rdc(`OFS_RESULT_HI, ex[i][9:2], "hi_left");
      apb(1, `OFS_ALIGN, 8'h00);
    end
  endtask

  task lock_tc;
    apb(1, `OFS_CONTROL_B, 8'h00);
    conv(11'h2aa);
    apb(1, `OFS_CONTROL_A, 8'h90);
    rdc(`OFS_RESULT_LO, 8'haa, "lo");
    conv(11'h155);
    rdc(`OFS_CONTROL_A, 8'h80, "done_locked");
    apb(1, `OFS_RESULT_LO, 8'hff);
    rdc(`OFS_RESULT_HI, 8'h02, "hi_locked");
    rdc(`OFS_RESULT_LO, 8'haa, "lo_kept");
    rdc(`OFS_RESULT_HI, 8'h02, "hi_kept");
    conv(11'h155);
    apb(1, `OFS_CONTROL_A, 8'h90);
    rdc(`OFS_RESULT_LO, 8'h55, "lo_new");
    rdc(`OFS_RESULT_HI, 8'h01, "hi_new");
  endtask

  task trig_tc;
    apb(1, `OFS_CONTROL_A, 8'ha0);
    for (int k = 1; k < 8; k++) begin
      apb(1, `OFS_CONTROL_B, k[7:0]);
      trig_src_flags <= ~(7'h01 << (k - 1));
      strt(0, "other_src");
      trig_src_flags <= 7'h7f;
      strt(1, "sel_src");
      apb(1, `OFS_CONTROL_A, 8'hb0);
      trig_src_flags <= 7'h00;
    end
    apb(1, `OFS_CONTROL_B, 8'h01);
    trig_src_flags <= 7'h02;
    strt(0, "unsel_rise");
    apb(1, `OFS_CONTROL_B, 8'h02);
    strt(1, "switch_set");
    // old source low, done high: only the free-running guard holds the start off
    trig_src_flags <= 7'h00;
    apb(1, `OFS_CONTROL_B, 8'h00);
    strt(0, "to_free");
    // done rising after a manual start must retrigger once in free running
    apb(1, `OFS_CONTROL_A, 8'hf0);
    wait_idle;
    strt(1, "free_run");
    apb(1, `OFS_CONTROL_A, 8'h80);
    apb(1, `OFS_CONTROL_B, 8'h01);
    trig_src_flags <= 7'h01;
    strt(0, "auto_off");
  endtask

  initial begin
    reset_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    diff_code = 11'h000;
    trig_src_flags = 7'h00;
    pin_in = 8'h00;
    repeat (10) @(posedge clk);
    reset_n <= 1;
    regs_tc;
    pins_tc;
    div_tc;
    conv_tc;
    lock_tc;
    trig_tc;
    tally_and_finish;
  end
endmodule // converter_result_and_trigger_ctrl_tb_top
